// ===== tcs_defines.svh
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH
// register index and byte addresses
`define TCS_CLK_CTRL_IDX  12'h08e
`define TCS_A_CLK_CTRL    (`TCS_CLK_CTRL_IDX * 12'h004)
`define TCS_A_T01_MODE    12'h000
`define TCS_A_T0_COUNT    12'h004
`define TCS_A_T1_COUNT    12'h008
`define TCS_A_CTRL25      12'h00c
`define TCS_A_CLK_CTRL1   12'h010
`define TCS_T25_PAGE      7'h01
// timer_clock_control fields
`define TCS_CC_PRESC      0
`define TCS_CC_T0_SEL     2
`define TCS_CC_T1_SEL     3
`define TCS_CC_T2_LO      4
`define TCS_CC_T2_HI      5
`define TCS_CC_T3_LO      6
`define TCS_CC_T3_HI      7
// timer45 byte selects
`define TCS_CC1_T4_LO     0
`define TCS_CC1_T4_HI     1
`define TCS_CC1_T5_LO     2
`define TCS_CC1_T5_HI     3
// timer01 mode fields
`define TCS_M_T0_MODE     0
`define TCS_M_T0_CNT      2
`define TCS_M_T0_RUN      3
`define TCS_M_T1_MODE     4
`define TCS_M_T1_CNT      6
`define TCS_M_T1_RUN      7
// timer2..5 control nibble fields
`define TCS_C_RUN         0
`define TCS_C_SPLIT       1
`define TCS_C_EXT         2
`define TCS_CTRL25_MASK   16'h7777
// reset values
`define TCS_CLK_CTRL_RST  8'h00
// divide ratios
`define TCS_DIV_SYS12     12
`define TCS_DIV_SYS4      4
`define TCS_DIV_SYS48     48
`define TCS_DIV_EXT8      8
// bus responses
`define TCS_RESP_OKAY     2'h0
`define TCS_RESP_SLVERR   2'h2
`endif

// ===== tcs_pkg.sv
package tcs_pkg;
  typedef enum logic [1:0] {
    tcs_mode_13bit   = 2'h0,
    tcs_mode_16bit   = 2'h1,
    tcs_mode_reload8 = 2'h2,
    tcs_mode_split   = 2'h3
  } tcs_mode01_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
  } tcs_rt_state_t;

  typedef struct packed {
    logic [7:0]  clk_ctrl;
    logic [3:0]  clk_ctrl1;
    logic [7:0]  t01_mode;
    logic [15:0] ctrl25;
    logic [15:0] t0_count;
    logic [15:0] t1_count;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [2:0]  prev;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_got;
    logic        w_got;
    logic [11:0] awaddr;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
  } tcs_state_t;

  function automatic logic [15:0] tcs_merge16(input logic [15:0] old,
                                              input logic [15:0] data,
                                              input logic [1:0]  strb);
    tcs_merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // one count step of timer 0/1 for the given mode
  function automatic logic [15:0] tcs_step01(input logic [15:0] c, input tcs_mode01_t m);
    logic [12:0] v;
    v = {c[15:8], c[4:0]} + 13'h0001;
    unique case (m)
      tcs_mode_13bit:   tcs_step01 = {v[12:5], c[7:5], v[4:0]};
      tcs_mode_16bit:   tcs_step01 = c + 16'h0001;
      tcs_mode_reload8: tcs_step01 = (c[7:0] == 8'hff) ? {c[15:8], c[15:8]}
                                                       : {c[15:8], c[7:0] + 8'h01};
      tcs_mode_split:   tcs_step01 = {c[15:8], c[7:0] + 8'h01};
    endcase
  endfunction
endpackage

// ===== tcs_divider.sv
`timescale 1ns/100ps
module tcs_divider #(
  parameter int N = 12
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // input events and divided tick
  input  wire logic tick_in,
  output logic      tick
);
  localparam int W = (N > 1) ? $clog2(N) : 1;
  localparam logic [W-1:0] LAST = W'(N - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } tcs_div_state_t;

  tcs_div_state_t s;
  tcs_div_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (tick_in) begin
      if (s.cnt == LAST) begin
        next_s.cnt = '0;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt = s.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  tick_one_cycle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |=> !tick)
    else $error("divided tick longer than one cycle");
endmodule

// ===== tcs_reload_timer.sv
`timescale 1ns/100ps
module tcs_reload_timer (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // count enables and mode
  input  wire logic        split,
  input  wire logic        en_lo,
  input  wire logic        en_hi,
  // software access
  input  wire logic        wr_count,
  input  wire logic        wr_reload,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  wstrb,
  output logic      [15:0] count,
  output logic      [15:0] reload
);
  tcs_pkg::tcs_rt_state_t s;
  tcs_pkg::tcs_rt_state_t next_s;

  always_comb begin
    next_s = s;
    if (!split) begin
      if (en_lo) begin
        next_s.count = (s.count == 16'hffff) ? s.reload : s.count + 16'h0001;
      end
    end else begin
      if (en_lo) begin
        next_s.count[7:0] = (s.count[7:0] == 8'hff) ? s.reload[7:0]
                                                   : s.count[7:0] + 8'h01;
      end
      if (en_hi) begin
        next_s.count[15:8] = (s.count[15:8] == 8'hff) ? s.reload[15:8]
                                                     : s.count[15:8] + 8'h01;
      end
    end
    // software write wins over a count in the same cycle
    if (wr_count) begin
      next_s.count = tcs_pkg::tcs_merge16(s.count, wdata, wstrb);
    end
    if (wr_reload) begin
      next_s.reload = tcs_pkg::tcs_merge16(s.reload, wdata, wstrb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count  = s.count;
  assign reload = s.reload;

  wide_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!split && en_lo && !wr_count && count == 16'hffff) |=> count == $past(reload))
    else $error("16-bit timer did not reload on overflow");
  upper_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (split && !en_hi && !wr_count) |=> count[15:8] == $past(count[15:8]))
    else $error("upper half moved without its clock");
endmodule

// ===== tcs_timer_clock_select.sv
// Operation
// - six sixteen-bit counter timers are provided
// - timers 0/1 have 13/16/reload8; split only timer0
// - timers 2-5 run 16-bit or split reload
// - timers 2-5 clock sys, sys/12, ext/8
// - counter mode counts falling edges on pin
// - prescale picks sys/12, /4, /48, ext/8
// - timer0 select: prescaled or system clock
// - timer1 select: prescaled or system clock
// - timer2 lower select: own source or system
// - timer2 upper select, split only
// - timer3 lower select: own source or system
// - timer3 upper select, split only
// - count mode bit picks pin edges
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "tcs_defines.svh"
module tcs_timer_clock_select (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // event and oscillator pins
  input  wire logic        timer0_event_pin,
  input  wire logic        timer1_event_pin,
  input  wire logic        ext_osc_pin,
  // axi write address
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi write response
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi read address
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi read data
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  tcs_pkg::tcs_state_t  s;
  tcs_pkg::tcs_state_t  next_s;
  tcs_pkg::tcs_mode01_t mode0;
  tcs_pkg::tcs_mode01_t mode1;

  logic [2:0]  pin_fall;
  logic        ext_rise;
  logic        tick12;
  logic        tick4;
  logic        tick48;
  logic        tick_ext8;
  logic        presc_tick;
  logic        run0;
  logic        run1;
  logic        t0_timer_en;
  logic        t1_timer_en;
  logic        t0_en;
  logic        th0_en;
  logic        t1_en;
  logic        commit;
  logic [11:0] waddr;
  logic        wr_t25;
  logic        wr_t0;
  logic        wr_t1;
  logic        wr_hit;
  logic [3:0]  lo_sel;
  logic [3:0]  hi_sel;
  logic [15:0] cnt25 [4];
  logic [15:0] rld25 [4];
  logic [11:0] raddr;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [15:0] c0;
  logic [15:0] c1;

  // pin edges are looked at only after the second flop
  assign pin_fall = s.prev & ~s.sync2;
  assign ext_rise = ~s.prev[2] & s.sync2[2];

  tcs_divider #(.N(`TCS_DIV_SYS12)) u_div12 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick_in (1'b1),
    .tick    (tick12)
  );
  tcs_divider #(.N(`TCS_DIV_SYS4)) u_div4 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick_in (1'b1),
    .tick    (tick4)
  );
  tcs_divider #(.N(`TCS_DIV_SYS48)) u_div48 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick_in (1'b1),
    .tick    (tick48)
  );
  // the oscillator is sampled, so it must stay below a quarter of aclk
  tcs_divider #(.N(`TCS_DIV_EXT8)) u_div_ext8 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick_in (ext_rise),
    .tick    (tick_ext8)
  );

  always_comb begin
    unique case (s.clk_ctrl[`TCS_CC_PRESC +: 2])
      2'h0: presc_tick = tick12;
      2'h1: presc_tick = tick4;
      2'h2: presc_tick = tick48;
      2'h3: presc_tick = tick_ext8;
    endcase
  end

  assign mode0 = tcs_pkg::tcs_mode01_t'(s.t01_mode[`TCS_M_T0_MODE +: 2]);
  assign mode1 = tcs_pkg::tcs_mode01_t'(s.t01_mode[`TCS_M_T1_MODE +: 2]);
  assign run0  = s.t01_mode[`TCS_M_T0_RUN];
  assign run1  = s.t01_mode[`TCS_M_T1_RUN];

  assign t0_timer_en = s.clk_ctrl[`TCS_CC_T0_SEL] | presc_tick;
  assign t1_timer_en = s.clk_ctrl[`TCS_CC_T1_SEL] | presc_tick;
  // the clock select is ignored while the count mode bit is set
  assign t0_en = run0 & (s.t01_mode[`TCS_M_T0_CNT] ? pin_fall[0] : t0_timer_en);
  assign t1_en = run1 & (mode1 != tcs_pkg::tcs_mode_split) &
                 (s.t01_mode[`TCS_M_T1_CNT] ? pin_fall[1] : t1_timer_en);
  // in split mode the upper half of timer0 is a timer only, run by timer1's run bit
  assign th0_en = run1 & t0_timer_en;

  assign commit = s.aw_got & s.w_got & ~s.bvalid;
  assign waddr  = {s.awaddr[11:2], 2'h0};
  assign wr_t25 = commit & (waddr[11:5] == `TCS_T25_PAGE);
  assign wr_t0  = commit & (waddr == `TCS_A_T0_COUNT);
  assign wr_t1  = commit & (waddr == `TCS_A_T1_COUNT);
  assign wr_hit = wr_t25 | wr_t0 | wr_t1 |
                  (waddr == `TCS_A_CLK_CTRL) | (waddr == `TCS_A_T01_MODE) |
                  (waddr == `TCS_A_CTRL25) | (waddr == `TCS_A_CLK_CTRL1);

  assign lo_sel = {s.clk_ctrl1[`TCS_CC1_T5_LO], s.clk_ctrl1[`TCS_CC1_T4_LO],
                   s.clk_ctrl[`TCS_CC_T3_LO], s.clk_ctrl[`TCS_CC_T2_LO]};
  assign hi_sel = {s.clk_ctrl1[`TCS_CC1_T5_HI], s.clk_ctrl1[`TCS_CC1_T4_HI],
                   s.clk_ctrl[`TCS_CC_T3_HI], s.clk_ctrl[`TCS_CC_T2_HI]};

  // timers 2 to 5, one instance each
  for (genvar i = 0; i < 4; i++) begin : g_rt
    logic src;
    logic run;
    assign run = s.ctrl25[4*i + `TCS_C_RUN];
    assign src = s.ctrl25[4*i + `TCS_C_EXT] ? tick_ext8 : tick12;
    tcs_reload_timer u_rt (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .split     (s.ctrl25[4*i + `TCS_C_SPLIT]),
      .en_lo     (run & (lo_sel[i] | src)),
      .en_hi     (run & (hi_sel[i] | src)),
      .wr_count  (wr_t25 & (waddr[4:3] == 2'(i)) & ~waddr[2]),
      .wr_reload (wr_t25 & (waddr[4:3] == 2'(i)) & waddr[2]),
      .wdata     (s.wdata),
      .wstrb     (s.wstrb),
      .count     (cnt25[i]),
      .reload    (rld25[i])
    );
  end

  // read decode
  assign raddr = {araddr[11:2], 2'h0};
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (raddr == `TCS_A_CLK_CTRL) begin
      rd_word = {24'h00_0000, s.clk_ctrl};
    end else if (raddr == `TCS_A_T01_MODE) begin
      rd_word = {24'h00_0000, s.t01_mode};
    end else if (raddr == `TCS_A_T0_COUNT) begin
      rd_word = {16'h0000, s.t0_count};
    end else if (raddr == `TCS_A_T1_COUNT) begin
      rd_word = {16'h0000, s.t1_count};
    end else if (raddr == `TCS_A_CTRL25) begin
      rd_word = {16'h0000, s.ctrl25};
    end else if (raddr == `TCS_A_CLK_CTRL1) begin
      rd_word = {28'h000_0000, s.clk_ctrl1};
    end else if (raddr[11:5] == `TCS_T25_PAGE) begin
      rd_word = {16'h0000, raddr[2] ? rld25[raddr[4:3]] : cnt25[raddr[4:3]]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // timer 0 and 1 counting
  always_comb begin
    c0 = s.t0_count;
    if (t0_en) begin
      c0 = tcs_pkg::tcs_step01(c0, mode0);
    end
    if (mode0 == tcs_pkg::tcs_mode_split && th0_en) begin
      c0[15:8] = c0[15:8] + 8'h01;
    end
    c1 = s.t1_count;
    if (t1_en) begin
      c1 = tcs_pkg::tcs_step01(c1, mode1);
    end
  end

  always_comb begin
    next_s = s;
    next_s.sync1 = {ext_osc_pin, timer1_event_pin, timer0_event_pin};
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;
    next_s.t0_count = c0;
    next_s.t1_count = c1;
    // read channel
    if (!s.rvalid && !s.arready) begin
      next_s.arready = 1'b1;
    end
    if (s.arready && arvalid) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rdata   = rd_word;
      next_s.rresp   = rd_hit ? `TCS_RESP_OKAY : `TCS_RESP_SLVERR;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end
    // write channels, taken in either order
    if (s.awready && awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (s.wready && wvalid) begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata[15:0];
      next_s.wstrb = wstrb[1:0];
    end
    if (commit) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = wr_hit ? `TCS_RESP_OKAY : `TCS_RESP_SLVERR;
      if (waddr == `TCS_A_CLK_CTRL && s.wstrb[0]) begin
        next_s.clk_ctrl = s.wdata[7:0];
      end
      if (waddr == `TCS_A_T01_MODE && s.wstrb[0]) begin
        next_s.t01_mode = s.wdata[7:0];
      end
      if (waddr == `TCS_A_CLK_CTRL1 && s.wstrb[0]) begin
        next_s.clk_ctrl1 = s.wdata[3:0];
      end
      if (waddr == `TCS_A_CTRL25) begin
        next_s.ctrl25 = tcs_pkg::tcs_merge16(s.ctrl25, s.wdata, s.wstrb) & `TCS_CTRL25_MASK;
      end
      // a software write overrides a count step in the same cycle
      if (wr_t0) begin
        next_s.t0_count = tcs_pkg::tcs_merge16(s.t0_count, s.wdata, s.wstrb);
      end
      if (wr_t1) begin
        next_s.t1_count = tcs_pkg::tcs_merge16(s.t1_count, s.wdata, s.wstrb);
      end
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
    next_s.wready  = ~next_s.w_got & ~next_s.bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rresp   = s.rresp;
  assign rdata   = s.rdata;

  div4_spacing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.clk_ctrl[1:0] == 2'h1 && presc_tick) |=> (!tick4)[*3] ##1 tick4)
    else $error("prescale by four has wrong period");
  div48_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick48 |=> (!tick48)[*8])
    else $error("prescale by 48 ticks too soon");
  pin_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (run0 && s.t01_mode[`TCS_M_T0_CNT] && mode0 == tcs_pkg::tcs_mode_16bit &&
     pin_fall[0] && !wr_t0) |=> s.t0_count == $past(s.t0_count) + 16'h0001)
    else $error("timer0 missed a pin falling edge");
  pin_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.t01_mode[`TCS_M_T0_CNT] && !pin_fall[0] && !(th0_en && mode0 == tcs_pkg::tcs_mode_split)
     && !wr_t0) |=> s.t0_count == $past(s.t0_count))
    else $error("timer0 counted without a pin edge");
  sys_clock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (run0 && !s.t01_mode[`TCS_M_T0_CNT] && s.clk_ctrl[`TCS_CC_T0_SEL] &&
     mode0 == tcs_pkg::tcs_mode_16bit && !wr_t0)
    |=> s.t0_count == $past(s.t0_count) + 16'h0001)
    else $error("timer0 did not run on system clock");
  presc_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!s.t01_mode[`TCS_M_T1_CNT] && !s.clk_ctrl[`TCS_CC_T1_SEL] && !presc_tick && !wr_t1)
    |=> s.t1_count == $past(s.t1_count))
    else $error("timer1 moved without a prescaled tick");
  reload8_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (t0_en && mode0 == tcs_pkg::tcs_mode_reload8 && s.t0_count[7:0] == 8'hff && !wr_t0)
    |=> s.t0_count[7:0] == $past(s.t0_count[15:8]))
    else $error("timer0 8-bit mode did not reload");
  t1_split_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode1 == tcs_pkg::tcs_mode_split && !wr_t1) |=> $stable(s.t1_count))
    else $error("timer1 ran in split mode");
  resp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  ext_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_ext8 |=> !tick_ext8 ##1 !tick_ext8)
    else $error("external divide tick too long");
  // the upper half of a split timer0 ignores the count mode bit
  th0_split_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (run1 && mode0 == tcs_pkg::tcs_mode_split && s.clk_ctrl[`TCS_CC_T0_SEL] && !wr_t0)
    |=> s.t0_count[15:8] == $past(s.t0_count[15:8]) + 8'h01)
    else $error("timer0 upper half missed a system clock step");
  t1_sys_clock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (run1 && !s.t01_mode[`TCS_M_T1_CNT] && s.clk_ctrl[`TCS_CC_T1_SEL] &&
     mode1 == tcs_pkg::tcs_mode_16bit && !wr_t1)
    |=> s.t1_count == $past(s.t1_count) + 16'h0001)
    else $error("timer1 did not run on system clock");
  // overflow cycles are left out so a reload cannot hide a missed step
  t2_lower_sys_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.ctrl25[`TCS_C_RUN] && !s.ctrl25[`TCS_C_SPLIT] && s.clk_ctrl[`TCS_CC_T2_LO] &&
     !wr_t25 && cnt25[0] != 16'hffff) |=> cnt25[0] == $past(cnt25[0]) + 16'h0001)
    else $error("timer2 did not run on system clock");
  t3_lower_sys_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.ctrl25[4 + `TCS_C_RUN] && s.clk_ctrl[`TCS_CC_T3_LO] && !wr_t25 &&
     cnt25[1][7:0] != 8'hff) |=> cnt25[1][7:0] == $past(cnt25[1][7:0]) + 8'h01)
    else $error("timer3 lower byte did not run on system clock");
endmodule

// ===== tcs_event_source.sv
`timescale 1ns/100ps
module tcs_event_source (
  // clock
  input  wire logic aclk,
  // event and oscillator pins
  output logic      timer0_event_pin,
  output logic      timer1_event_pin,
  output logic      ext_osc_pin
);
  logic       osc_on;
  logic [1:0] osc_cnt;

  initial begin
    timer0_event_pin = 1'b1;
    timer1_event_pin = 1'b1;
    ext_osc_pin      = 1'b0;
    osc_on           = 1'b0;
    osc_cnt          = 2'h0;
  end

  // aclk/8 keeps the oscillator well under the quarter-rate ceiling
  always @(posedge aclk) begin
    osc_cnt <= osc_cnt + 2'h1;
    if (osc_on && osc_cnt == 2'h3) begin
      ext_osc_pin <= !ext_osc_pin;
    end
  end

  task automatic osc(input bit on);
    @(posedge aclk);
    osc_on <= on;
  endtask

  // a faster source would be missed by the two-flop sampler
  task automatic pulses(input bit sel, input int n, input int hold);
    int h;
    h = (hold < 2) ? 2 : hold;
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      if (sel) begin
        timer1_event_pin <= 1'b0;
      end else begin
        timer0_event_pin <= 1'b0;
      end
      repeat (h) @(posedge aclk);
      timer0_event_pin <= 1'b1;
      timer1_event_pin <= 1'b1;
      repeat (h) @(posedge aclk);
    end
  endtask
endmodule

// ===== testbench.sv
`timescale 1ns/100ps
`include "tcs_defines.svh"
module testbench;
  localparam logic [11:0] CC  = `TCS_A_CLK_CTRL;
  localparam logic [11:0] MD  = `TCS_A_T01_MODE;
  localparam logic [11:0] CT  = `TCS_A_CTRL25;
  localparam logic [11:0] T0C = 12'h004;
  localparam logic [11:0] T1C = 12'h008;
  localparam logic [11:0] T2C = 12'h020;
  localparam logic [11:0] T3C = 12'h028;
  localparam logic [11:0] T4C = 12'h030;
  localparam logic [11:0] T5C = 12'h038;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        t0_pin, t1_pin, osc_pin;
  logic [11:0] awaddr = 12'h0;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [11:0] araddr = 12'h0;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc_n = 0;

  always #12.5 aclk = !aclk;

  tcs_timer_clock_select tcs_timer_clock_select_i (
    .aclk(aclk), .aresetn(aresetn), .timer0_event_pin(t0_pin),
    .timer1_event_pin(t1_pin), .ext_osc_pin(osc_pin),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  tcs_event_source tcs_event_source_i (
    .aclk(aclk), .timer0_event_pin(t0_pin), .timer1_event_pin(t1_pin),
    .ext_osc_pin(osc_pin));

  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a hung handshake ends here
  always @(posedge aclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // divider phase and bus latency leave a small spread
  task automatic near(input logic [31:0] got, input int exp, input int tol, input string m);
    cmp_count++;
    if (((got + tol >= exp) && (got <= exp + tol)) !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
      // bready waits for bvalid so the response must be held meanwhile
      if (bvalid && !bready) begin
        bready <= 1'b1;
      end
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, `TCS_RESP_OKAY}, "write response");
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd(a, d, r);
    chk({30'h0, r}, {30'h0, `TCS_RESP_OKAY}, "read response");
  endtask

  task automatic reg_test();
    logic [31:0] d;
    logic [1:0]  r;
    rd(CC, d);
    chk(d, 32'h0, "clock control reset");
    wr(CC, 32'ha5);
    rd(CC, d);
    chk(d, 32'ha5, "clock control a5");
    wr(CC, 32'h5a);
    rd(CC, d);
    chk(d, 32'h5a, "clock control 5a");
    axi_wr(12'h200, 32'hff, r);
    chk({30'h0, r}, {30'h0, `TCS_RESP_SLVERR}, "unmapped write");
    axi_rd(12'h200, d, r);
    chk({30'h0, r}, {30'h0, `TCS_RESP_SLVERR}, "unmapped read");
    chk(d, 32'h0, "unmapped data");
    rd(CC, d);
    chk(d, 32'h5a, "clock control kept");
  endtask

  // exact counts: pin edges only, clock select must have no effect
  task automatic ev_case(input logic [7:0] cc, input logic [11:0] ca, input logic [31:0] md,
                         input logic [15:0] c0, input bit sel, input int n, input int hold,
                         input logic [15:0] exp);
    logic [31:0] got;
    wr(CC, {24'h0, cc});
    wr(ca, {16'h0, c0});
    wr(MD, md);
    tcs_event_source_i.pulses(sel, n, hold);
    repeat (8) @(posedge aclk);
    wr(MD, 32'h0);
    rd(ca, got);
    chk(got, {16'h0, exp}, "event count");
  endtask

  // dhi zero: whole count at rate 1/dlo; else split bytes at 1/dlo and 1/dhi
  task automatic clk_case(input logic [7:0] cc, input logic [11:0] ca, input logic [11:0] ma,
                          input logic [31:0] on, input int cyc, input int dlo, input int dhi);
    logic [31:0] got;
    wr(CC, {24'h0, cc});
    wr(ca, 32'h0);
    wr(ma, on);
    repeat (cyc) @(posedge aclk);
    wr(ma, 32'h0);
    rd(ca, got);
    if (dhi == 0) begin
      near(got, (cyc + 5) / dlo, (dlo == 1) ? 3 : 2, "timer rate");
    end else begin
      near({24'h0, got[7:0]}, (cyc + 5) / dlo, (dlo == 1) ? 3 : 2, "lower byte rate");
      near({24'h0, got[15:8]}, (cyc + 5) / dhi, (dhi == 1) ? 3 : 2, "upper byte rate");
    end
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    reg_test();
    ev_case(8'h04, T0C, 32'h0d, 16'h0000, 1'b0, 5, 2, 16'h0005);
    ev_case(8'h08, T1C, 32'hd0, 16'h0000, 1'b1, 7, 3, 16'h0007);
    ev_case(8'h00, T0C, 32'h0c, 16'h001f, 1'b0, 1, 2, 16'h0100);
    ev_case(8'h00, T0C, 32'h0e, 16'ha0ff, 1'b0, 1, 2, 16'ha0a0);
    ev_case(8'h00, T0C, 32'h0f, 16'h12ff, 1'b0, 1, 2, 16'h1200);
    ev_case(8'h00, T1C, 32'hf0, 16'h1234, 1'b1, 1, 2, 16'h1234);
    clk_case(8'h00, T0C, MD, 32'h09, 480, 12, 0);
    clk_case(8'h01, T0C, MD, 32'h09, 480, 4, 0);
    clk_case(8'h02, T0C, MD, 32'h09, 480, 48, 0);
    tcs_event_source_i.osc(1'b1);
    clk_case(8'h03, T0C, MD, 32'h09, 640, 64, 0);
    clk_case(8'h00, T2C, CT, 32'h05, 640, 64, 0);
    tcs_event_source_i.osc(1'b0);
    clk_case(8'h04, T0C, MD, 32'h09, 200, 1, 0);
    clk_case(8'h01, T1C, MD, 32'h90, 480, 4, 0);
    clk_case(8'h08, T1C, MD, 32'h90, 200, 1, 0);
    clk_case(8'h04, T0C, MD, 32'h8b, 200, 1, 1);
    clk_case(8'h20, T2C, CT, 32'h01, 480, 12, 0);
    clk_case(8'h10, T2C, CT, 32'h01, 200, 1, 0);
    clk_case(8'h10, T2C, CT, 32'h03, 200, 1, 12);
    clk_case(8'h20, T2C, CT, 32'h03, 200, 12, 1);
    clk_case(8'h80, T3C, CT, 32'h10, 480, 12, 0);
    clk_case(8'h40, T3C, CT, 32'h30, 200, 1, 12);
    clk_case(8'h80, T3C, CT, 32'h30, 200, 12, 1);
    clk_case(8'h00, T4C, CT, 32'h0100, 480, 12, 0);
    clk_case(8'h00, T5C, CT, 32'h1000, 480, 12, 0);
    stop_test();
  end
endmodule
